// ===== hw/bridge_defines.svh
// Constants for the serial-to-DRAM bridge: offsets, field positions, resets and timing.
`ifndef BRIDGE_DEFINES_SVH
`define BRIDGE_DEFINES_SVH

// Address widths and last row numbers.
`define ADDR_W              22
`define ROW_W               11
`define ROW_1M_W            10
`define ROW_1M_LAST         11'h3ff
`define ROW_4M_LAST         11'h7ff

// APB register map.
`define PADDR_W             12
`define CTRL_OFFSET         12'h000
`define STATUS_OFFSET       12'h004
`define CTRL_RESET          32'h0000_0001
`define CTRL_REFRESH_EN_BIT 0
`define STATUS_BUSY_BIT     24
`define STATUS_REFPEND_BIT  25
`define STATUS_ACCPEND_BIT  26
`define STATUS_MODE4M_BIT   27

// Refresh timing, counted in oscillator periods.
`define OSC_FREQ_KHZ        8000
`define REFRESH_PERIOD_NS   15000
`define REFRESH_OSC_TICKS   ((`REFRESH_PERIOD_NS * `OSC_FREQ_KHZ) / 1000000)
`define REF_TICK_W          8

// DRAM strobe timing in ns, turned into pclk cycles rounded up.
`define PCLK_PERIOD_NS      50
`define RAS_TO_CAS_NS       100
`define CAS_PULSE_NS        200
`define REF_RAS_NS          150
`define PRECHARGE_NS        100
`define NS_TO_CYC(ns)       (((ns) + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define TIMER_W             3

`endif

// ===== hw/bridge_pkg.sv
// Types shared by the serial-to-DRAM bridge.
package bridge_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACC_ROW,
      ST_ACC_RAS,
      ST_ACC_CAS,
      ST_REF_ROW,
      ST_REF_RAS,
      ST_PRECHARGE
   } state_t;

   typedef struct packed {
      logic       osc;
      logic       ser_data;
      logic       ser_clk_n;
      logic       load_n;
      logic       acc_clk_n;
      logic       wr_n;
      logic       wdata;
      logic       rdata;
      logic       size4m;
      logic       bank_hi;
      logic       bank_lo;
      logic       bank_le_n;
      logic [3:0] cs_n;
   } pin_in_t;

   typedef struct packed {
      logic       ras_n;
      logic [3:0] cas_n;
      logic       we_n;
   } dram_ctrl_t;

endpackage

// ===== hw/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      // Strobe pins idle high, so a high reset value shows no false fall at release.
      if (!rst_n)
      begin
         meta_reg <= '1;
         sync_out <= '1;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // pin_sync

// ===== hw/serial_to_dram_bridge.sv
// Serial-address to DRAM bridge with built-in RAS-only refresh and an APB control port.
`include "bridge_defines.svh"

module serial_to_dram_bridge (
   // APB slave
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [`PADDR_W-1:0]  paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Controller serial interface
   input  wire logic                 serial_addr_in,
   input  wire logic                 serial_addr_clk_n,
   input  wire logic                 addr_load_strobe_n,
   input  wire logic                 access_clk_n,
   input  wire logic                 access_write_n,
   input  wire logic                 ctrl_data_in,
   output logic                      read_data_out,
   // Configuration pins and oscillator input
   input  wire logic                 mem_size_sel,
   input  wire logic                 bank_sel_lo,
   input  wire logic                 bank_sel_hi,
   input  wire logic                 bank_latch_en_n,
   input  wire logic                 chip_sel1_n,
   input  wire logic                 chip_sel2_n,
   input  wire logic                 chip_sel3_n,
   input  wire logic                 chip_sel4_n,
   input  wire logic                 osc_in,
   // DRAM side
   output logic      [`ROW_W-1:0]    mem_addr_out,
   output logic                      row_strobe_n,
   output logic                      col_strobe1_n,
   output logic                      col_strobe2_n,
   output logic                      col_strobe3_n,
   output logic                      col_strobe4_n,
   output logic                      mem_write_en_n,
   output logic                      mem_write_data_out,
   input  wire logic                 mem_read_data_in
);

   localparam logic [`TIMER_W-1:0] RCD_CYC =
      `TIMER_W'(`NS_TO_CYC(`RAS_TO_CAS_NS));
   localparam logic [`TIMER_W-1:0] CAS_CYC =
      `TIMER_W'(`NS_TO_CYC(`CAS_PULSE_NS));
   localparam logic [`TIMER_W-1:0] REF_CYC =
      `TIMER_W'(`NS_TO_CYC(`REF_RAS_NS));
   localparam logic [`TIMER_W-1:0] PRE_CYC =
      `TIMER_W'(`NS_TO_CYC(`PRECHARGE_NS));
   localparam logic [`REF_TICK_W-1:0] REF_TICK_LAST =
      `REF_TICK_W'(`REFRESH_OSC_TICKS - 1);

   bridge_pkg::pin_in_t    pin_raw;
   bridge_pkg::pin_in_t    pin_s;
   bridge_pkg::pin_in_t    pin_prev_reg;
   bridge_pkg::state_t     state_reg;
   bridge_pkg::dram_ctrl_t dram_reg;

   logic [`ADDR_W-1:0]     shift_reg;
   logic [`ADDR_W-1:0]     addr_cnt_reg;
   logic [`ADDR_W-1:0]     acc_addr_reg;
   logic                   acc_write_reg;
   logic                   acc_pend_reg;
   logic                   ref_pend_reg;
   logic [`ROW_W-1:0]      ref_row_reg;
   logic [`REF_TICK_W-1:0] ref_tick_reg;
   logic [`TIMER_W-1:0]    timer_reg;
   logic [1:0]             bank_reg;
   logic [31:0]            ctrl_reg;
   logic [`ROW_W-1:0]      addr_reg;
   logic                   rdata_reg;
   logic                   wdata_reg;

   logic                   ser_clk_fall;
   logic                   load_fall;
   logic                   acc_fall;
   logic                   osc_rise;
   logic                   acc_take;
   logic                   ref_take;
   logic                   timer_done;
   logic [3:0]             cas_sel;
   logic [`ROW_W-1:0]      acc_row;
   logic [`ROW_W-1:0]      acc_col;
   logic [`ROW_W-1:0]      idle_row;
   logic [`ADDR_W-1:0]     load_value;
   logic                   apb_access;
   logic                   ctrl_hit;
   logic                   status_hit;

   // All non-APB input pins are asynchronous to pclk and pass two flops first.
   assign pin_raw = '{
      osc:       osc_in,
      ser_data:  serial_addr_in,
      ser_clk_n: serial_addr_clk_n,
      load_n:    addr_load_strobe_n,
      acc_clk_n: access_clk_n,
      wr_n:      access_write_n,
      wdata:     ctrl_data_in,
      rdata:     mem_read_data_in,
      size4m:    mem_size_sel,
      bank_hi:   bank_sel_hi,
      bank_lo:   bank_sel_lo,
      bank_le_n: bank_latch_en_n,
      cs_n:      {chip_sel4_n, chip_sel3_n, chip_sel2_n, chip_sel1_n}
   };

   pin_sync #(
      .WIDTH ($bits(bridge_pkg::pin_in_t))
   ) u_pin_sync (
      .clk      (pclk),
      .rst_n    (presetn),
      .async_in (pin_raw),
      .sync_out (pin_s)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_prev_reg <= '1;
      else
         pin_prev_reg <= pin_s;
   end

   assign ser_clk_fall = pin_prev_reg.ser_clk_n & ~pin_s.ser_clk_n;
   assign load_fall    = pin_prev_reg.load_n & ~pin_s.load_n;
   assign acc_fall     = pin_prev_reg.acc_clk_n & ~pin_s.acc_clk_n;
   // The 8 MHz input is sampled at 20 MHz, so every edge is still seen.
   assign osc_rise     = ~pin_prev_reg.osc & pin_s.osc;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         shift_reg <= '0;
      else if (ser_clk_fall)
         shift_reg <= {shift_reg[`ADDR_W-2:0], pin_s.ser_data};
   end

   assign load_value = pin_s.size4m ? shift_reg :
                       {2'h0, shift_reg[`ADDR_W-3:0]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         addr_cnt_reg <= '0;
      else if (load_fall)
         addr_cnt_reg <= load_value;
      else if (acc_fall)
         addr_cnt_reg <= pin_s.size4m ? addr_cnt_reg + 1'b1 :
                         {2'h0, addr_cnt_reg[`ADDR_W-3:0] + 1'b1};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_addr_reg  <= '0;
         acc_write_reg <= 1'b0;
         wdata_reg     <= 1'b0;
      end
      else if (acc_fall)
      begin
         acc_addr_reg  <= addr_cnt_reg;
         acc_write_reg <= ~pin_s.wr_n;
         wdata_reg     <= pin_s.wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bank_reg <= 2'h0;
      else if (!pin_s.bank_le_n)
         bank_reg <= {pin_s.bank_hi, pin_s.bank_lo};
   end

   always_comb
   begin
      cas_sel = 4'h0;
      if (pin_s.size4m)
      begin
         if (pin_s.cs_n != 4'hf)
         begin
            if (bank_reg == 2'h0)
               cas_sel = 4'h1;
            else if (bank_reg == 2'h1)
               cas_sel = 4'h2;
            else if (bank_reg == 2'h2)
               cas_sel = 4'h4;
            else
               cas_sel = 4'h8;
         end
      end
      else
         cas_sel = ~pin_s.cs_n;
   end

   assign acc_row = pin_s.size4m ? acc_addr_reg[`ADDR_W-1:`ROW_W] :
                    {1'b0, acc_addr_reg[2*`ROW_1M_W-1:`ROW_1M_W]};
   assign acc_col = pin_s.size4m ? acc_addr_reg[`ROW_W-1:0] :
                    {1'b0, acc_addr_reg[`ROW_1M_W-1:0]};
   assign idle_row = pin_s.size4m ? addr_cnt_reg[`ADDR_W-1:`ROW_W] :
                     {1'b0, addr_cnt_reg[2*`ROW_1M_W-1:`ROW_1M_W]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ref_tick_reg <= '0;
      else if (osc_rise)
         ref_tick_reg <= (ref_tick_reg == REF_TICK_LAST) ? '0 :
                         ref_tick_reg + 1'b1;
   end

   assign timer_done = (timer_reg == '0);
   assign acc_take   = (state_reg == bridge_pkg::ST_IDLE) & acc_pend_reg;
   assign ref_take   = (state_reg == bridge_pkg::ST_IDLE) & ~acc_pend_reg &
                       ref_pend_reg;

   // A new event in the take cycle keeps its request pending.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc_pend_reg <= 1'b0;
      else if (acc_fall)
         acc_pend_reg <= 1'b1;
      else if (acc_take)
         acc_pend_reg <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ref_pend_reg <= 1'b0;
      else if (osc_rise && ref_tick_reg == REF_TICK_LAST &&
               ctrl_reg[`CTRL_REFRESH_EN_BIT])
         ref_pend_reg <= 1'b1;
      else if (ref_take)
         ref_pend_reg <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ref_row_reg <= '0;
      else if (ref_take)
         ref_row_reg <= (ref_row_reg == (pin_s.size4m ? `ROW_4M_LAST :
                         `ROW_1M_LAST)) ? '0 : ref_row_reg + 1'b1;
   end

   // Strobe sequencer; one owner of RAS and CAS at a time.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= bridge_pkg::ST_IDLE;
         dram_reg  <= '1;
         timer_reg <= '0;
         addr_reg  <= '0;
      end
      else
      begin
         if (!timer_done)
            timer_reg <= timer_reg - 1'b1;
         case (state_reg)
            bridge_pkg::ST_IDLE:
            begin
               dram_reg <= '1;
               addr_reg <= idle_row;
               if (acc_take)
               begin
                  state_reg <= bridge_pkg::ST_ACC_ROW;
                  addr_reg  <= acc_row;
               end
               else if (ref_take)
               begin
                  state_reg <= bridge_pkg::ST_REF_ROW;
                  addr_reg  <= ref_row_reg;
               end
            end
            bridge_pkg::ST_ACC_ROW:
            begin
               dram_reg.ras_n <= 1'b0;
               dram_reg.we_n  <= ~acc_write_reg;
               timer_reg      <= RCD_CYC - 1'b1;
               state_reg      <= bridge_pkg::ST_ACC_RAS;
            end
            bridge_pkg::ST_ACC_RAS:
            begin
               addr_reg <= acc_col;
               if (timer_done)
               begin
                  dram_reg.cas_n <= ~cas_sel;
                  timer_reg      <= CAS_CYC - 1'b1;
                  state_reg      <= bridge_pkg::ST_ACC_CAS;
               end
            end
            bridge_pkg::ST_ACC_CAS:
            begin
               if (timer_done)
               begin
                  dram_reg  <= '1;
                  timer_reg <= PRE_CYC - 1'b1;
                  state_reg <= bridge_pkg::ST_PRECHARGE;
               end
            end
            bridge_pkg::ST_REF_ROW:
            begin
               dram_reg.ras_n <= 1'b0;
               dram_reg.cas_n <= 4'hf;
               dram_reg.we_n  <= 1'b1;
               timer_reg      <= REF_CYC - 1'b1;
               state_reg      <= bridge_pkg::ST_REF_RAS;
            end
            bridge_pkg::ST_REF_RAS:
            begin
               if (timer_done)
               begin
                  dram_reg.ras_n <= 1'b1;
                  timer_reg      <= PRE_CYC - 1'b1;
                  state_reg      <= bridge_pkg::ST_PRECHARGE;
               end
            end
            bridge_pkg::ST_PRECHARGE:
            begin
               if (timer_done)
                  state_reg <= bridge_pkg::ST_IDLE;
            end
            default:
               state_reg <= bridge_pkg::ST_IDLE;
         endcase
      end
   end

   // read data captured
   // The pin passes two sync flops, so the last CAS cycle sees data 100 ns in.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata_reg <= 1'b0;
      else if (state_reg == bridge_pkg::ST_ACC_CAS && timer_done &&
               !acc_write_reg)
         rdata_reg <= pin_s.rdata;
   end

   assign mem_addr_out       = addr_reg;
   assign row_strobe_n       = dram_reg.ras_n;
   assign col_strobe1_n      = dram_reg.cas_n[0];
   assign col_strobe2_n      = dram_reg.cas_n[1];
   assign col_strobe3_n      = dram_reg.cas_n[2];
   assign col_strobe4_n      = dram_reg.cas_n[3];
   assign mem_write_en_n     = dram_reg.we_n;
   assign mem_write_data_out = wdata_reg;
   assign read_data_out      = rdata_reg;

   // APB slave: zero wait states, unmapped addresses answer with an error.
   assign apb_access = psel & penable;
   assign pready     = 1'b1;

   always_comb
   begin
      ctrl_hit   = 1'b0;
      status_hit = 1'b0;
      if (paddr == `CTRL_OFFSET)
         ctrl_hit = 1'b1;
      else if (paddr == `STATUS_OFFSET)
         status_hit = 1'b1;
   end

   assign pslverr = apb_access & ~ctrl_hit & ~status_hit;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_reg <= `CTRL_RESET;
      else if (apb_access && pwrite && ctrl_hit)
         ctrl_reg <= {31'h0, pwdata[`CTRL_REFRESH_EN_BIT]};
   end

   always_comb
   begin
      prdata = 32'h0;
      if (ctrl_hit)
         prdata = ctrl_reg;
      else if (status_hit)
      begin
         prdata[`ADDR_W-1:0]          = addr_cnt_reg;
         prdata[`STATUS_BUSY_BIT]     = (state_reg != bridge_pkg::ST_IDLE);
         prdata[`STATUS_REFPEND_BIT]  = ref_pend_reg;
         prdata[`STATUS_ACCPEND_BIT]  = acc_pend_reg;
         prdata[`STATUS_MODE4M_BIT]   = pin_s.size4m;
      end
   end

endmodule // serial_to_dram_bridge

// ===== verif/serial_to_dram_bridge_properties.sv
// Pin-level assertions for the serial-to-DRAM bridge.
`include "bridge_defines.svh"
module bridge_checker (
   // Clock, reset and APB
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [`PADDR_W-1:0] paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pslverr,
   // Configuration pins
   input wire logic                mem_size_sel,
   input wire logic                chip_sel1_n,
   input wire logic                chip_sel2_n,
   input wire logic                chip_sel3_n,
   input wire logic                chip_sel4_n,
   // DRAM side
   input wire logic [`ROW_W-1:0]   mem_addr_out,
   input wire logic                row_strobe_n,
   input wire logic                col_strobe1_n,
   input wire logic                col_strobe2_n,
   input wire logic                col_strobe3_n,
   input wire logic                col_strobe4_n,
   input wire logic                mem_write_en_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire [3:0] cas_n    = {col_strobe4_n, col_strobe3_n, col_strobe2_n, col_strobe1_n};
   wire [3:0] cs_n     = {chip_sel4_n, chip_sel3_n, chip_sel2_n, chip_sel1_n};
   wire       cas_lo   = cas_n != 4'hf;
   wire       unmapped = paddr != `CTRL_OFFSET && paddr != `STATUS_OFFSET;

   // A column pulse lasts four cycles and is then released.
   sequence s_cas_pulse;
      cas_lo [*4] ##1 !cas_lo;
   endsequence
   // Precharge keeps the row strobe high before any new cycle.
   sequence s_precharge;
      row_strobe_n [*3];
   endsequence

   property p_one_bank;
      mem_size_sel && cas_lo |-> $onehot(~cas_n);
   endproperty
   property p_cs_gate;
      cas_lo |-> (mem_size_sel ? cs_n != 4'hf : cas_n == cs_n);
   endproperty
   property p_cas_in_ras;
      cas_lo |-> !row_strobe_n;
   endproperty
   property p_cas_width;
      $rose(cas_lo) |-> s_cas_pulse;
   endproperty
   property p_addr_hold;
      cas_lo && $past(cas_lo) |-> $stable(mem_addr_out);
   endproperty
   property p_precharge;
      $rose(row_strobe_n) |-> s_precharge;
   endproperty
   property p_we_access;
      $fell(mem_write_en_n) |-> !row_strobe_n ##[1:4] cas_lo;
   endproperty
   // A row pulse without any column strobe is a three-cycle refresh.
   property p_ref_ras;
      $rose(row_strobe_n) && !$past(cas_lo) |->
         !$past(row_strobe_n, 3) && $past(row_strobe_n, 4);
   endproperty
   property p_unmapped;
      psel && penable && unmapped |-> pslverr && prdata == 32'h0;
   endproperty

   a_one_bank: assert property (p_one_bank)
      else $error("several column strobes in 4-Mbit mode");
   a_cs_gate: assert property (p_cs_gate)
      else $error("column strobes disagree with chip selects");
   a_cas_in_ras: assert property (p_cas_in_ras)
      else $error("column strobe without row strobe");
   a_cas_width: assert property (p_cas_width)
      else $error("column pulse not four cycles");
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved under column strobe");
   a_precharge: assert property (p_precharge)
      else $error("row strobe precharge too short");
   a_we_access: assert property (p_we_access)
      else $error("write enable outside an access");
   a_ref_ras: assert property (p_ref_ras)
      else $error("refresh row pulse not three cycles");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
endmodule // bridge_checker

bind serial_to_dram_bridge bridge_checker chk_u (
   .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr, .mem_size_sel,
   .chip_sel1_n, .chip_sel2_n, .chip_sel3_n, .chip_sel4_n, .mem_addr_out, .row_strobe_n,
   .col_strobe1_n, .col_strobe2_n, .col_strobe3_n, .col_strobe4_n, .mem_write_en_n
);

// ===== verif/dram_model.sv
// Behavioural set of x1 DRAMs answering the bridge's strobes.
module dram_model (
   // Strobes and address
   input  wire logic        ras_n,
   input  wire logic [3:0]  cas_n,
   input  wire logic [10:0] addr,
   // Data
   input  wire logic        we_n,
   input  wire logic        din,
   output logic             dout
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [10:0] row = 11'h000;
   logic        v   = 1'b0;
   logic        mem [int];
   int          k;
   initial dout = 1'b1;
   always @(negedge ras_n) #5 row = addr;
   always @(negedge (&cas_n))
   begin
      #5;
      k = {row, addr, cas_n};
      if (!we_n)
         mem[k] = din;
      v    = mem.exists(k) ? mem[k] : ~v;
      dout = v;
   end
   // The line floats once released, so show the inverse of the last bit.
   always @(posedge (&cas_n)) dout = ~v;
endmodule // dram_model

// ===== verif/test_serial_to_dram_bridge.sv
// Self-checking bench for the serial-to-DRAM bridge.
`include "bridge_defines.svh"
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH %s expected %0h seen %0h", what, (exp), (got)); end end
module test_serial_to_dram_bridge;
   timeunit 1ns;
   timeprecision 100ps;
   logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic                pwrite = 1'b0, serial_addr_in = 1'b0, serial_addr_clk_n = 1'b1;
   logic                addr_load_strobe_n = 1'b1, access_clk_n = 1'b1, access_write_n = 1'b1;
   logic                ctrl_data_in = 1'b0, m4 = 1'b1, bank_sel_lo = 1'b0, bank_sel_hi = 1'b0;
   logic                bank_latch_en_n = 1'b0, osc_in = 1'b0, ras_q = 1'b1, had_cas = 1'b0;
   logic [`PADDR_W-1:0] paddr = 12'h000;
   logic [31:0]         pwdata = 32'h0, rd, r, seed = 32'h6ced337e;
   logic [21:0]         a, addr;
   logic [10:0]         row_seen;
   logic [3:0]          cs_n = 4'he;
   logic [3:0]          cs_tab [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h5};
   logic                err, mem_m [int];
   int                  checked = 0, fails = 0, refreshes = 0;
   wire  [31:0]         prdata;
   wire  [10:0]         mem_addr_out;
   wire  [3:0]          cas_n;
   wire                 pready, pslverr, read_data_out, row_strobe_n, mem_write_en_n;
   wire                 mem_write_data_out, mem_read_data_in;

   serial_to_dram_bridge dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .serial_addr_in, .serial_addr_clk_n, .addr_load_strobe_n, .access_clk_n,
      .access_write_n, .ctrl_data_in, .read_data_out, .mem_size_sel(m4), .bank_sel_lo,
      .bank_sel_hi, .bank_latch_en_n, .chip_sel1_n(cs_n[0]), .chip_sel2_n(cs_n[1]),
      .chip_sel3_n(cs_n[2]), .chip_sel4_n(cs_n[3]), .osc_in, .mem_addr_out, .row_strobe_n,
      .col_strobe1_n(cas_n[0]), .col_strobe2_n(cas_n[1]), .col_strobe3_n(cas_n[2]),
      .col_strobe4_n(cas_n[3]), .mem_write_en_n, .mem_write_data_out, .mem_read_data_in
   );
   dram_model mem_u (.ras_n(row_strobe_n), .cas_n, .addr(mem_addr_out),
      .we_n(mem_write_en_n), .din(mem_write_data_out), .dout(mem_read_data_in));

   initial forever #25 pclk = ~pclk;
   initial forever #62.5 osc_in = ~osc_in;

   // A row pulse that saw no column strobe is counted as a refresh.
   always @(posedge pclk)
   begin
      ras_q <= row_strobe_n;
      if (ras_q && !row_strobe_n)
         row_seen <= mem_addr_out;
      if (cas_n != 4'hf)
         had_cas <= 1'b1;
      else if (ras_q && !row_strobe_n)
         had_cas <= 1'b0;
      if (!ras_q && row_strobe_n && !had_cas)
         refreshes++;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic wc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [`PADDR_W-1:0] ad, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic shift_addr(input logic [21:0] v);
      for (int i = 21; i >= 0; i--)
      begin
         serial_addr_in <= v[i];
         wc(4);
         serial_addr_clk_n <= 1'b0;
         wc(4);
         serial_addr_clk_n <= 1'b1;
      end
      wc(4);
      addr_load_strobe_n <= 1'b0;
      wc(4);
      addr_load_strobe_n <= 1'b1;
      wc(4);
      addr = v & (m4 ? 22'h3fffff : 22'h0fffff);
   endtask

   task automatic access(input int wr, input logic [3:0] ec);
      logic d;
      int   k;
      r = rnd();
      d = r[0];
      k = {addr, ec};
      access_write_n <= (wr == 0);
      ctrl_data_in   <= d;
      wc(4);
      access_clk_n <= 1'b0;
      do @(negedge pclk); while (cas_n == 4'hf);
      `CHK("column strobes", ec, cas_n)
      `CHK("column", m4 ? addr[10:0] : {1'b0, addr[9:0]}, mem_addr_out)
      `CHK("row", m4 ? addr[21:11] : {1'b0, addr[19:10]}, row_seen)
      `CHK("write enable", (wr == 0), mem_write_en_n)
      if (wr)
         `CHK("write data", d, mem_write_data_out)
      @(posedge pclk);
      access_clk_n <= 1'b1;
      do @(negedge pclk); while (cas_n != 4'hf);
      @(negedge pclk);
      if (wr)
         mem_m[k] = d;
      else
         `CHK("read data", mem_m[k], read_data_out)
      addr = (addr + 22'h1) & (m4 ? 22'h3fffff : 22'h0fffff);
      @(posedge pclk);
   endtask

   task automatic run_pass(input logic [21:0] v);
      logic [3:0] ec;
      for (int wr = 1; wr >= 0; wr--)
      begin
         shift_addr(v);
         for (int i = 0; i < 5; i++)
         begin
            if (m4)
            begin
               {bank_sel_hi, bank_sel_lo} <= (i == 4) ? 2'b11 : i[1:0];
               ec = ~(4'h1 << ((i == 4) ? 3 : i));
            end
            else
            begin
               cs_n <= cs_tab[i];
               ec = cs_tab[i];
            end
            wc(4);
            if (m4 && i == 4)
            begin
               bank_latch_en_n <= 1'b1;
               wc(4);
               {bank_sel_hi, bank_sel_lo} <= 2'b00;
               wc(4);
            end
            access(wr, ec);
            bank_latch_en_n <= 1'b0;
         end
      end
   endtask

   task automatic tally_and_finish();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      fails++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial
   begin
      wc(8);
      presetn <= 1'b1;
      wc(1);
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      `CHK("ctrl reset", `CTRL_RESET, rd)
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      `CHK("status after reset", 32'h1 << `STATUS_MODE4M_BIT, rd)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      apb(1'b1, `STATUS_OFFSET, 32'hffff_ffff);
      `CHK("status write error", 1'b0, err)
      $display("test registers done");
      r = rnd();
      a = r[21:0];
      shift_addr(a);
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      `CHK("loaded address", a, rd[21:0])
      run_pass(a);
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      `CHK("counter after burst", addr, rd[21:0])
      $display("test 4-Mbit done");
      m4 <= 1'b0;
      wc(4);
      run_pass(22'h3ffffe);
      $display("test 1-Mbit done");
      refreshes = 0;
      wc(700);
      `CHK("refresh count", 1'b1, refreshes inside {2, 3})
      apb(1'b1, `CTRL_OFFSET, 32'h0);
      wc(10);
      refreshes = 0;
      wc(700);
      `CHK("refresh off", 0, refreshes)
      $display("test refresh done");
      tally_and_finish();
   end
endmodule // test_serial_to_dram_bridge
